/* phpp_defines.svh */
// constants of the parallel high-voltage programming port
`ifndef PHPP_DEFINES_SVH
`define PHPP_DEFINES_SVH

// clock period
`define PHPP_CLK_NS 10

// action-select codes
`define PHPP_ACT_ADDR 2'b00
`define PHPP_ACT_DATA 2'b01
`define PHPP_ACT_CMD 2'b10

// command bytes
`define PHPP_CMD_NOP 8'h00
`define PHPP_CMD_WR_FUSE 8'h40
`define PHPP_CMD_WR_LOCK 8'h20
`define PHPP_CMD_WR_FLASH 8'h10
`define PHPP_CMD_WR_EE 8'h11
`define PHPP_CMD_RD_SIG 8'h08
`define PHPP_CMD_RD_FUSE 8'h04
`define PHPP_CMD_RD_FLASH 8'h02
`define PHPP_CMD_RD_EE 8'h03

// array geometry
`define PHPP_FLASH_AW 11
`define PHPP_PAGE_WB 5
`define PHPP_PAGE_LAST 5'h1F
`define PHPP_EE_AW 6
`define PHPP_EE_PB 2
`define PHPP_EE_LAST 2'h3

// fuse and lock reset values, lock mode 3 pattern
`define PHPP_FUSE_RST 8'hFF
`define PHPP_LOCK_RST 8'hFF
`define PHPP_LOCK_MODE3 2'b00
`define PHPP_IDLE_BYTE 8'hFF

// self-timed write durations
`define PHPP_T_FLASH_NS 4500000
`define PHPP_T_EE_NS 3600000
`define PHPP_FUSE_WAIT_CYC 1000

`endif

/* phpp_edge.sv */
// edge detector turning a synchronous pin level into a one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
module phpp_edge #(
    parameter bit RISE = 1'b1
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic level,
    output logic pulse
);
    logic prev_q;

    // idle level is the inactive one, so no pulse comes out of reset
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            prev_q <= ~RISE;
        end else begin
            prev_q <= level;
        end
    end

    // pulse on the chosen edge only
    assign pulse = RISE ? (level & ~prev_q) : (~level & prev_q);
endmodule
`default_nettype wire

/* phpp_mem.sv */
// simple memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module phpp_mem #(
    parameter int AW = 4,
    parameter int DW = 8
) (
    input wire logic mclk,
    input wire logic wrEn,
    input wire logic [AW-1:0] wrAddr,
    input wire logic [DW-1:0] wrData,
    input wire logic [AW-1:0] rdAddr,
    output logic [DW-1:0] rdData
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    // no reset: array contents are nonvolatile by intent
    always_ff @(posedge mclk) begin
        if (wrEn) begin
            mem[wrAddr] <= wrData;
        end
        rdData <= mem[rdAddr];
    end
endmodule
`default_nettype wire

/* phpp_pkg.sv */
// types of the parallel high-voltage programming port
package phpp_pkg;
    typedef logic [7:0] phpp_byte_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_COPY = 3'b010,
        ST_WAIT = 3'b100
    } phpp_state_e;
    typedef enum logic [3:0] {
        OP_FLASH = 4'b0001,
        OP_EE = 4'b0010,
        OP_FUSE = 4'b0100,
        OP_LOCK = 4'b1000
    } phpp_op_e;
endpackage

/* phpp_port.sv */
// parallel high-voltage programming port, device side
`include "phpp_defines.svh"
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE_01: action 10, byte select 0, clock-in loads command; 0x10 is flash write.
// RULE_02: action 00, byte select 0, clock-in loads low address byte.
// RULE_03: action 01 loads data byte; byte select picks low or high.
// RULE_04: page-load pulse latches data bytes into page buffer at word.
// RULE_05: low address bits pick word, upper bits pick page.
// RULE_06: action 00, byte select 1, clock-in loads high address byte.
// RULE_07: write strobe under flash write programs page; busy until done.
// RULE_08: no-operation command resets internal write session state.
// RULE_09: eeprom page load per location, then write strobe programs page.
// RULE_10: read flash drives low or high word byte while enable low.
// RULE_11: read eeprom drives addressed byte while enable low.
// RULE_12: fuse write stores low data byte on write strobe; busy.
// RULE_13: byte selects pick low, high or extended fuse on write.
// RULE_14: lock write programs zero bits; refused once lock mode 3.
// RULE_15: lock bits never return to unprogrammed via lock or fuse write.
// RULE_16: fuse/lock read: selects 00 low, 11 high, 10 ext, 01 lock.
// RULE_17: signature command drives signature byte chosen by low address.
// RULE_18: signature command, address 0, byte select 1 gives calibration.
// RULE_19: ready/busy is 0 while programming, 1 when ready.
// RULE_20: data bus driven only while output enable is low.
// RULE_21: command and address stay loaded across operations.
// RULE_22: write strobes ignored while busy.
module phpp_port #(
    parameter int unsigned FLASH_WAIT = `PHPP_T_FLASH_NS / `PHPP_CLK_NS,
    parameter int unsigned EE_WAIT = `PHPP_T_EE_NS / `PHPP_CLK_NS,
    parameter int unsigned FUSE_WAIT = `PHPP_FUSE_WAIT_CYC,
    // arbitrary identification values
    parameter logic [7:0] SIG_BYTE0 = 8'hA5,
    parameter logic [7:0] SIG_BYTE1 = 8'h5A,
    parameter logic [7:0] SIG_BYTE2 = 8'h3C,
    parameter logic [7:0] CAL_BYTE = 8'h80
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic actionSelHi,
    input wire logic actionSelLo,
    input wire logic byteSelPrimary,
    input wire logic byteSelSecondary,
    input wire logic loadClockIn,
    input wire logic pageLatchStrobe,
    input wire logic writeStrobeN,
    input wire logic outEnN,
    input wire phpp_pkg::phpp_byte_t dataIn,
    output phpp_pkg::phpp_byte_t dataOut,
    output logic dataOe,
    output logic readyBusyOut
);
    import phpp_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic clkPulse, pagePulse, wrPulse;
    logic [1:0] action;
    phpp_byte_t cmd_q, addrLo_q, addrHi_q, dataLo_q, dataHi_q;
    phpp_byte_t fuseLo_q, fuseHi_q, fuseExt_q, lock_q;
    phpp_byte_t eeBuf_q [0:3];
    logic [3:0] eeMask_q;
    phpp_state_e state_q;
    phpp_op_e op_q;
    logic [`PHPP_PAGE_WB-1:0] copyIdx_q, copyDly_q;
    logic copyVal_q;
    logic [`PHPP_FLASH_AW-`PHPP_PAGE_WB-1:0] flashPage_q;
    logic [`PHPP_EE_AW-`PHPP_EE_PB-1:0] eePage_q;
    logic [31:0] waitCnt_q;
    logic [15:0] bufRd, flashRd;
    phpp_byte_t eeRd, readByte;
    logic eeWrEn;
    logic [`PHPP_EE_PB-1:0] eeIdx;

    assign action = {actionSelHi, actionSelLo};
    assign eeIdx = copyIdx_q[`PHPP_EE_PB-1:0];

    // ------------------------------------------------------------
    // strobe edge detection
    // ------------------------------------------------------------
    phpp_edge #(.RISE(1'b1)) uClk (
        .mclk(mclk), .nrst(nrst), .level(loadClockIn), .pulse(clkPulse)
    );
    phpp_edge #(.RISE(1'b1)) uPage (
        .mclk(mclk), .nrst(nrst), .level(pageLatchStrobe),
        .pulse(pagePulse)
    );
    phpp_edge #(.RISE(1'b0)) uWr (
        .mclk(mclk), .nrst(nrst), .level(writeStrobeN), .pulse(wrPulse)
    );

    // fuse and lock read mapping by the two byte selects
    function automatic phpp_byte_t fuseReadSel(input logic bs2,
                                               input logic bs1,
                                               input phpp_byte_t lo,
                                               input phpp_byte_t hi,
                                               input phpp_byte_t ext,
                                               input phpp_byte_t lk);
        case ({bs2, bs1})
            2'b00: fuseReadSel = lo;
            2'b11: fuseReadSel = hi;
            2'b10: fuseReadSel = ext;
            default: fuseReadSel = lk;
        endcase
    endfunction

    // ------------------------------------------------------------
    // command, address and data loading
    // ------------------------------------------------------------
    // nothing but clock-in changes these, so they survive every op
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cmd_q <= `PHPP_CMD_NOP;
            addrLo_q <= 8'h00;
            addrHi_q <= 8'h00;
            dataLo_q <= 8'hFF;
            dataHi_q <= 8'hFF;
        end else if (clkPulse) begin // [RULE_21]
            case (action)
                `PHPP_ACT_CMD: begin
                    if (!byteSelPrimary) begin
                        cmd_q <= dataIn; // [RULE_01]
                    end
                end
                `PHPP_ACT_ADDR: begin
                    if (byteSelPrimary) begin
                        addrHi_q <= dataIn; // [RULE_06]
                    end else begin
                        addrLo_q <= dataIn; // [RULE_02]
                    end
                end
                `PHPP_ACT_DATA: begin
                    if (byteSelPrimary) begin
                        dataHi_q <= dataIn; // [RULE_03]
                    end else begin
                        dataLo_q <= dataIn; // [RULE_03]
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // page buffers
    // ------------------------------------------------------------
    // flash buffer: word picked by low address bits
    phpp_mem #(.AW(`PHPP_PAGE_WB), .DW(16)) uFlashBuf (
        .mclk(mclk),
        .wrEn(pagePulse && cmd_q != `PHPP_CMD_WR_EE), // [RULE_04]
        .wrAddr(addrLo_q[`PHPP_PAGE_WB-1:0]), // [RULE_05]
        .wrData({dataHi_q, dataLo_q}),
        .rdAddr(copyIdx_q),
        .rdData(bufRd)
    );

    // eeprom buffer keeps a mask so only loaded bytes are written
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            eeMask_q <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                eeBuf_q[i] <= 8'hFF;
            end
        end else begin
            // a latch in the clearing cycle is kept: set wins over clear
            if ((clkPulse && action == `PHPP_ACT_CMD && !byteSelPrimary
                 && dataIn == `PHPP_CMD_NOP)
                || (state_q == ST_WAIT && op_q == OP_EE
                    && waitCnt_q == 32'd1)) begin
                eeMask_q <= 4'h0; // [RULE_08]
            end
            if (pagePulse && cmd_q == `PHPP_CMD_WR_EE) begin
                eeBuf_q[addrLo_q[`PHPP_EE_PB-1:0]] <= dataLo_q; // [RULE_09]
                eeMask_q[addrLo_q[`PHPP_EE_PB-1:0]] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // nonvolatile arrays
    // ------------------------------------------------------------
    // buffer read is registered, so flash write trails copyIdx by one
    phpp_mem #(.AW(`PHPP_FLASH_AW), .DW(16)) uFlash (
        .mclk(mclk),
        .wrEn(copyVal_q),
        .wrAddr({flashPage_q, copyDly_q}), // [RULE_05]
        .wrData(bufRd),
        .rdAddr({addrHi_q[`PHPP_FLASH_AW-9:0], addrLo_q}),
        .rdData(flashRd)
    );

    assign eeWrEn = state_q == ST_COPY && op_q == OP_EE && eeMask_q[eeIdx];

    phpp_mem #(.AW(`PHPP_EE_AW), .DW(8)) uEeprom (
        .mclk(mclk),
        .wrEn(eeWrEn),
        .wrAddr({eePage_q, eeIdx}),
        .wrData(eeBuf_q[eeIdx]),
        .rdAddr(addrLo_q[`PHPP_EE_AW-1:0]),
        .rdData(eeRd)
    );

    // ------------------------------------------------------------
    // self-timed write sequencer
    // ------------------------------------------------------------
    // strobes in copy or wait fall through: busy blocks a second start
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            op_q <= OP_FLASH;
            copyIdx_q <= '0;
            waitCnt_q <= 32'd0;
            flashPage_q <= '0;
            eePage_q <= '0;
            readyBusyOut <= 1'b1;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (wrPulse) begin // [RULE_22]
                        copyIdx_q <= '0;
                        flashPage_q <= {addrHi_q[`PHPP_FLASH_AW-9:0],
                            addrLo_q[7:`PHPP_PAGE_WB]}; // [RULE_05]
                        eePage_q <= addrLo_q[`PHPP_EE_AW-1:`PHPP_EE_PB];
                        case (cmd_q)
                            `PHPP_CMD_WR_FLASH: begin
                                op_q <= OP_FLASH;
                                state_q <= ST_COPY;
                                readyBusyOut <= 1'b0; // [RULE_07]
                            end
                            `PHPP_CMD_WR_EE: begin
                                op_q <= OP_EE;
                                state_q <= ST_COPY;
                                readyBusyOut <= 1'b0; // [RULE_09]
                            end
                            `PHPP_CMD_WR_FUSE: begin
                                op_q <= OP_FUSE;
                                state_q <= ST_WAIT;
                                waitCnt_q <= FUSE_WAIT;
                                readyBusyOut <= 1'b0; // [RULE_12]
                            end
                            `PHPP_CMD_WR_LOCK: begin
                                op_q <= OP_LOCK;
                                state_q <= ST_WAIT;
                                waitCnt_q <= FUSE_WAIT;
                                readyBusyOut <= 1'b0; // [RULE_19]
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                ST_COPY: begin
                    copyIdx_q <= copyIdx_q + 1'b1;
                    if (op_q == OP_EE && eeIdx == `PHPP_EE_LAST) begin
                        state_q <= ST_WAIT;
                        waitCnt_q <= EE_WAIT;
                    end else if (op_q == OP_FLASH
                                 && copyIdx_q == `PHPP_PAGE_LAST) begin
                        state_q <= ST_WAIT;
                        waitCnt_q <= FLASH_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (waitCnt_q <= 32'd1) begin
                        state_q <= ST_IDLE;
                        readyBusyOut <= 1'b1; // [RULE_19]
                    end else begin
                        waitCnt_q <= waitCnt_q - 32'd1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    readyBusyOut <= 1'b1;
                end
            endcase
        end
    end

    // flash write strobe delayed one cycle to meet buffer read data
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            copyVal_q <= 1'b0;
            copyDly_q <= '0;
        end else begin
            copyVal_q <= state_q == ST_COPY && op_q == OP_FLASH; // [RULE_07]
            copyDly_q <= copyIdx_q;
        end
    end

    // ------------------------------------------------------------
    // fuse and lock storage
    // ------------------------------------------------------------
    // values commit at the strobe; busy then only models the timing
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            fuseLo_q <= `PHPP_FUSE_RST;
            fuseHi_q <= `PHPP_FUSE_RST;
            fuseExt_q <= `PHPP_FUSE_RST;
            lock_q <= `PHPP_LOCK_RST;
        end else if (state_q == ST_IDLE && wrPulse) begin
            if (cmd_q == `PHPP_CMD_WR_FUSE) begin
                case ({byteSelSecondary, byteSelPrimary}) // [RULE_13]
                    2'b00: fuseLo_q <= dataLo_q; // [RULE_12]
                    2'b01: fuseHi_q <= dataLo_q;
                    2'b10: fuseExt_q <= dataLo_q;
                    default: begin
                    end
                endcase
            end else if (cmd_q == `PHPP_CMD_WR_LOCK
                         && lock_q[1:0] != `PHPP_LOCK_MODE3) begin
                lock_q <= lock_q & dataLo_q; // [RULE_14] [RULE_15]
            end
        end
    end

    // ------------------------------------------------------------
    // read-back bus
    // ------------------------------------------------------------
    // byte chosen by the held command and the live selects
    always_comb begin
        case (cmd_q)
            `PHPP_CMD_RD_FLASH: begin
                readByte = byteSelPrimary ? flashRd[15:8]
                                          : flashRd[7:0]; // [RULE_10]
            end
            `PHPP_CMD_RD_EE: begin
                readByte = eeRd; // [RULE_11]
            end
            `PHPP_CMD_RD_FUSE: begin
                readByte = fuseReadSel(byteSelSecondary, byteSelPrimary,
                    fuseLo_q, fuseHi_q, fuseExt_q, lock_q); // [RULE_16]
            end
            `PHPP_CMD_RD_SIG: begin
                if (byteSelPrimary) begin
                    readByte = (addrLo_q == 8'h00) ? CAL_BYTE // [RULE_18]
                                                   : `PHPP_IDLE_BYTE;
                end else begin
                    case (addrLo_q) // [RULE_17]
                        8'h00: readByte = SIG_BYTE0;
                        8'h01: readByte = SIG_BYTE1;
                        8'h02: readByte = SIG_BYTE2;
                        default: readByte = `PHPP_IDLE_BYTE;
                    endcase
                end
            end
            default: begin
                readByte = `PHPP_IDLE_BYTE;
            end
        endcase
    end

    // output drive follows the enable pin one cycle later
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            dataOut <= 8'h00;
            dataOe <= 1'b0;
        end else begin
            dataOe <= ~outEnN; // [RULE_20]
            dataOut <= outEnN ? 8'h00 : readByte; // [RULE_20]
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);

    a_cmd_load: assert property (clkPulse && action == `PHPP_ACT_CMD // [RULE_01]
        && !byteSelPrimary |=> cmd_q == $past(dataIn))
        else $error("command not loaded");
    a_addr_low: assert property (clkPulse && action == `PHPP_ACT_ADDR // [RULE_02]
        && !byteSelPrimary |=> addrLo_q == $past(dataIn) && $stable(addrHi_q))
        else $error("low address not loaded");
    a_addr_high: assert property (clkPulse && action == `PHPP_ACT_ADDR // [RULE_06]
        && byteSelPrimary |=> addrHi_q == $past(dataIn) && $stable(addrLo_q))
        else $error("high address not loaded");
    a_data_high: assert property (clkPulse && action == `PHPP_ACT_DATA // [RULE_03]
        && byteSelPrimary |=> dataHi_q == $past(dataIn) && $stable(dataLo_q))
        else $error("high data not loaded");
    a_flash_busy: assert property (wrPulse && state_q == ST_IDLE // [RULE_07]
        && cmd_q == `PHPP_CMD_WR_FLASH |=> !readyBusyOut [*8])
        else $error("flash write not busy");
    a_busy_state: assert property (readyBusyOut == (state_q == ST_IDLE)) // [RULE_19]
        else $error("ready does not match sequencer");
    a_oe_follow: assert property (outEnN |=> !dataOe ##1 !dataOe || !$past(outEnN)) // [RULE_20]
        else $error("bus driven with enable high");
    a_nop_clear: assert property (clkPulse && action == `PHPP_ACT_CMD // [RULE_08]
        && !byteSelPrimary && !pagePulse
        && dataIn == `PHPP_CMD_NOP |=> eeMask_q == 4'h0)
        else $error("no-op did not clear session");
    a_lock_mono: assert property ((lock_q & ~$past(lock_q)) == 8'h00) // [RULE_15]
        else $error("lock bit erased");
    a_lock_mode3: assert property (lock_q[1:0] == `PHPP_LOCK_MODE3 // [RULE_14]
        |=> $stable(lock_q))
        else $error("lock changed in mode 3");
    a_busy_ignore: assert property (state_q == ST_WAIT && waitCnt_q > 32'd1 // [RULE_22]
        && wrPulse |=> state_q == ST_WAIT && $stable(op_q))
        else $error("strobe disturbed busy write");
    a_ee_read: assert property (!outEnN && cmd_q == `PHPP_CMD_RD_EE // [RULE_11]
        |=> dataOut == $past(eeRd))
        else $error("eeprom byte not driven");

    c_flash_prog: cover property (state_q == ST_COPY && op_q == OP_FLASH
        ##1 state_q == ST_WAIT);
    c_ee_prog: cover property (eeWrEn);
    c_lock_refused: cover property (wrPulse && state_q == ST_IDLE
        && cmd_q == `PHPP_CMD_WR_LOCK && lock_q[1:0] == `PHPP_LOCK_MODE3);
    c_cal_read: cover property (dataOe && cmd_q == `PHPP_CMD_RD_SIG
        && byteSelPrimary);
endmodule
`default_nettype wire

/* phpp_prog.sv */
// behavioural model of the external parallel programmer
`timescale 1ns/1ps
`default_nettype none
module phpp_prog (
    input wire logic mclk,
    input wire logic dataOe,
    input wire phpp_pkg::phpp_byte_t dataOut,
    output logic actionSelHi,
    output logic actionSelLo,
    output logic byteSelPrimary,
    output logic byteSelSecondary,
    output logic loadClockIn,
    output logic pageLatchStrobe,
    output logic writeStrobeN,
    output logic outEnN,
    output phpp_pkg::phpp_byte_t dataIn
);
    import phpp_pkg::*;
    phpp_byte_t drv = 8'h00;
    logic rel = 1'b0;
    // --------------------------------
    // shared bus
    // --------------------------------
    // released bus shows the inverse, so a stale byte never passes
    assign dataIn = dataOe ? dataOut : (rel ? ~drv : drv);
    // idle pin levels from time zero
    initial begin
        {actionSelHi, actionSelLo} = 2'b11;
        {byteSelPrimary, byteSelSecondary} = 2'b00;
        {loadClockIn, pageLatchStrobe} = 2'b00;
        {writeStrobeN, outEnN} = 2'b11;
    end
    task automatic step();
        @(posedge mclk);
        #1;
    endtask
    // one load: action and byte select first, then a clock-in pulse
    task automatic load(input logic [1:0] act, input logic bs,
                        input phpp_byte_t v);
        {actionSelHi, actionSelLo} = act;
        byteSelPrimary = bs;
        drv = v;
        rel = 1'b0;
        step();
        loadClockIn = 1'b1;
        step();
        loadClockIn = 1'b0;
        step();
        {actionSelHi, actionSelLo} = 2'b11;
        // let an edge pass so a following load never reassigns in one step
        step();
    endtask
    // page-load pulse; the port ignores byte select here
    task automatic latch(input logic bs);
        byteSelPrimary = bs;
        step();
        pageLatchStrobe = 1'b1;
        step();
        pageLatchStrobe = 1'b0;
        step();
    endtask
    // low write pulse, selects chosen before it falls
    task automatic strobe(input logic b1, input logic b2);
        {byteSelPrimary, byteSelSecondary} = {b1, b2};
        step();
        writeStrobeN = 1'b0;
        step();
        writeStrobeN = 1'b1;
        byteSelSecondary = 1'b0;
        step();
    endtask
    task automatic read_en(input logic b1, input logic b2);
        {byteSelPrimary, byteSelSecondary} = {b1, b2};
        rel = 1'b1;
        outEnN = 1'b0;
        repeat (3) step();
    endtask
    task automatic read_off();
        outEnN = 1'b1;
        step();
        step();
    endtask
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking bench for the programming port
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import phpp_pkg::*;
    logic mclk, nrst, aHi, aLo, bs1, bs2, lck, pgl, wrN, oeN, oe, rdy;
    phpp_byte_t din, dout;
    int failures, checks_done, i;
    phpp_byte_t sig [4] = '{8'hA5, 8'h5A, 8'h3C, 8'h80};
    phpp_byte_t fv [3] = '{8'hE2, 8'hD9, 8'hFE};
    phpp_byte_t lv [4] = '{8'hFE, 8'hFF, 8'hFC, 8'hF3};
    phpp_byte_t le [4] = '{8'hFE, 8'hFE, 8'hFC, 8'hFC};
    // short waits keep the run small
    phpp_port #(.FLASH_WAIT(20), .EE_WAIT(20), .FUSE_WAIT(5))
        dut (.mclk(mclk), .nrst(nrst),
        .actionSelHi(aHi), .actionSelLo(aLo), .byteSelPrimary(bs1),
        .byteSelSecondary(bs2), .loadClockIn(lck), .pageLatchStrobe(pgl),
        .writeStrobeN(wrN), .outEnN(oeN), .dataIn(din), .dataOut(dout),
        .dataOe(oe), .readyBusyOut(rdy));
    phpp_prog prog (.mclk(mclk), .dataOe(oe), .dataOut(dout),
        .actionSelHi(aHi), .actionSelLo(aLo), .byteSelPrimary(bs1),
        .byteSelSecondary(bs2), .loadClockIn(lck), .pageLatchStrobe(pgl),
        .writeStrobeN(wrN), .outEnN(oeN), .dataIn(din));
    // --------------------------------
    // helpers
    // --------------------------------
    task automatic chk(input string n, input phpp_byte_t s,
                       input phpp_byte_t e);
        checks_done++;
        if (s !== e) begin
            failures++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic complete_run();
        if (failures == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // write pulse, then a bounded wait for ready
    task automatic wr(input logic b1, input logic b2);
        int n;
        prog.strobe(b1, b2);
        chk("busy", {7'h00, rdy}, 8'h00);
        n = 0;
        while (rdy !== 1'b1 && n < 300) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 300) begin
            failures++;
            complete_run();
        end
    endtask
    task automatic rd(input logic b1, input logic b2, input phpp_byte_t e);
        prog.read_en(b1, b2);
        chk("drive", {7'h00, oe}, 8'h01);
        chk("data", dout, e);
        prog.read_off();
        chk("release", {7'h00, oe}, 8'h00);
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        failures = 0;
        checks_done = 0;
        nrst = 1'b0;
        repeat (4) @(posedge mclk);
        #1 nrst = 1'b1;
        // flash word at page bit in address low byte
        prog.load(2'b10, 1'b0, 8'h10);
        prog.load(2'b00, 1'b0, 8'h21);
        prog.load(2'b01, 1'b0, 8'h34);
        prog.load(2'b01, 1'b1, 8'h12);
        prog.latch(1'b1);
        prog.load(2'b00, 1'b1, 8'h01);
        wr(1'b0, 1'b0);
        prog.load(2'b10, 1'b0, 8'h00);
        prog.load(2'b10, 1'b0, 8'h02);
        rd(1'b0, 1'b0, 8'h34);
        rd(1'b1, 1'b0, 8'h12);
        // one eeprom location
        prog.load(2'b10, 1'b0, 8'h11);
        prog.load(2'b00, 1'b1, 8'h00);
        prog.load(2'b00, 1'b0, 8'h05);
        prog.load(2'b01, 1'b0, 8'h77);
        prog.latch(1'b0);
        wr(1'b0, 1'b0);
        prog.load(2'b10, 1'b0, 8'h03);
        rd(1'b0, 1'b0, 8'h77);
        // low, high and extended fuses, then read back all three
        prog.load(2'b10, 1'b0, 8'h40);
        for (i = 0; i < 3; i++) begin
            prog.load(2'b01, 1'b0, fv[i]);
            wr(i == 1, i == 2);
        end
        prog.load(2'b10, 1'b0, 8'h04);
        rd(1'b0, 1'b0, fv[0]);
        rd(1'b1, 1'b1, fv[1]);
        rd(1'b0, 1'b1, fv[2]);
        // lock bits only program, and freeze in mode 3
        for (i = 0; i < 4; i++) begin
            prog.load(2'b10, 1'b0, 8'h20);
            prog.load(2'b01, 1'b0, lv[i]);
            wr(1'b0, 1'b0);
            prog.load(2'b10, 1'b0, 8'h04);
            rd(1'b1, 1'b0, le[i]);
        end
        // signature bytes and calibration byte
        prog.load(2'b10, 1'b0, 8'h08);
        for (i = 0; i < 3; i++) begin
            prog.load(2'b00, 1'b0, i[7:0]);
            rd(1'b0, 1'b0, sig[i]);
        end
        prog.load(2'b00, 1'b0, 8'h00);
        rd(1'b1, 1'b0, sig[3]);
        complete_run();
    end
endmodule
`default_nettype wire
